// file: hdl/dsa_pkg.sv
// Package with constants, field positions, types and parity helpers of the DMA store access core
`default_nettype none
package dsa_pkg;
	localparam int NUM_DEV = 16;
	localparam int DEV_W = 4;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 20;
	localparam int HIGH_W = 4;
	localparam int CMD_W = 8;
	localparam int ST_W = 8;
	// Host request register fields and the host write register state field
	localparam int RQ_UNIT_LO = 10;
	localparam int RQ_UNIT_W = 6;
	localparam int RQ_SUB_LO = 6;
	localparam int RQ_SUB_W = 4;
	localparam int RQ_MEM_BIT = 9;
	localparam int RQ_SEL_LO = 5;
	localparam int RQ_ADV_BIT = 4;
	localparam int RQ_DEV_LO = 0;
	localparam int HW_STATE_LO = 8;
	// Unit addresses on the request register; values are arbitrary
	localparam logic [5:0] UNIT_ADDR_DEF = 6'h2A;
	localparam logic [5:0] PCH_ADDR_DEF = 6'h15;
	// Sequencer state values
	localparam logic [7:0] ST_IDLE = 8'h00;
	localparam logic [7:0] ST_ACTIVE = 8'h55;
	localparam logic [7:0] ST_ALT = 8'hAA;
	localparam logic [7:0] ST_REQ = 8'h0F;
	localparam logic [7:0] ST_S1 = 8'h1E;
	localparam logic [7:0] ST_S2 = 8'h3C;
	localparam logic [7:0] ST_S3 = 8'h78;
	localparam logic [7:0] ST_LAST = 8'h87;
	// Two-out-of-four store commands
	localparam logic [3:0] CMD_READ = 4'h3;
	localparam logic [3:0] CMD_WRITE = 4'h5;
	typedef enum logic [3:0] {
		SEL_DTB = 4'h0,
		SEL_PAL = 4'h1,
		SEL_FAL = 4'h2,
		SEL_MDT = 4'h3,
		SEL_EDT = 4'h4,
		SEL_MSK = 4'h5,
		SEL_PAH = 4'h6,
		SEL_FAH = 4'h7,
		SEL_FLAG = 4'h8,
		SEL_STORE_COMMAND = 4'h9,
		SEL_STATE = 4'hA
	} dsa_sel_t;
	typedef struct packed {
		logic reset;
		logic clr_req;
		logic clr_state;
		logic set_req;
		logic load;
		logic step;
	} dsa_strobe_t;
	typedef struct packed {
		logic go;
		logic repeater_en;
		logic [19:0] address;
		logic [1:0] addr_par;
		logic [7:0] command;
		logic [15:0] data;
		logic [1:0] data_par;
		logic data_oe;
	} dsa_bus_t;
	typedef struct packed {
		logic store_error;
		logic data_parity;
		logic dtb_parity;
		logic counter;
		logic pa_gt_fa;
		logic fa_parity;
		logic pa_parity;
	} dsa_err_t;
	function automatic logic [3:0] dsa_odd_nib(input logic [15:0] v);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < 4; i++) begin
			p[i] = ~^v[4*i +: 4];
		end
		return p;
	endfunction
	function automatic logic [1:0] dsa_odd_byte(input logic [15:0] v);
		return {~^v[15:8], ~^v[7:0]};
	endfunction
endpackage
`default_nettype wire

// file: hdl/dsa_store_ctl.sv
// Store bus seize, go and completion handshake flops
`default_nettype none
module dsa_store_ctl (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clear_in,
	input wire logic trigger_in,
	input wire logic bus_go_in,
	input wire logic complete_in,
	input wire logic error_c_in,
	output logic go_out,
	output logic seize_out,
	output logic data_ready_out,
	output logic data_load_out
);
	logic pending;
	logic ready_enable;
	logic release_enable;
	logic bus_idle;

	assign bus_idle = !go_out && !bus_go_in && !complete_in && !error_c_in;
	assign data_load_out = ready_enable && complete_in;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pending <= 1'b0;
		end else if (clear_in) begin
			pending <= 1'b0;
		end else if (trigger_in) begin
			pending <= 1'b1;
		end else if (seize_out) begin
			pending <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_ready_out <= 1'b0;
		end else if (clear_in || trigger_in) begin
			data_ready_out <= 1'b0;
		end else if (ready_enable && complete_in) begin
			data_ready_out <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			seize_out <= 1'b0;
		end else if (clear_in) begin
			seize_out <= 1'b0;
		end else if (pending && bus_idle) begin
			seize_out <= 1'b1;
		end else if (release_enable && !complete_in) begin
			seize_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			go_out <= 1'b0;
		end else if (clear_in || release_enable) begin
			go_out <= 1'b0;
		end else if (seize_out) begin
			go_out <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ready_enable <= 1'b0;
		end else if (clear_in || data_ready_out) begin
			ready_enable <= 1'b0;
		end else if (complete_in && go_out) begin
			ready_enable <= 1'b1;
		end
	end

	// Release holds off a new access until completion has dropped
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			release_enable <= 1'b0;
		end else if (clear_in) begin
			release_enable <= 1'b0;
		end else if (ready_enable && complete_in) begin
			release_enable <= 1'b1;
		end else if (!complete_in) begin
			release_enable <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: hdl/dsa_core.sv
// DMA store access core: per-device registers, sequencer, address monitor and store bus gating
// Functional notes
// - Store error during access sets internal error flags and aborts device communication
// - Store word read with bad parity is captured in the error word register
// - Trigger clears data ready; idle bus sets seize, seize sets go
// - Complete sets ready enable; ready and release follow; release drops go
// - Up to sixteen devices, private registers in RAMs indexed by device address
// - Buffer and address lows per device; memory data, error word, mask shared
// - Go low enables repeaters; go high isolates them and gates present address out
// - Memory data drives store bus when write is 0, loads when 1
// - High address registers hold bits 16 to 19 of 20-bit addresses
// - Store command register carries two-of-four commands onto the store bus
// - Present and final addresses carry four odd parity bits, checked
// - Buffer and memory data carry odd parity over each byte
// - Two store address parity bits: bits 0 to 7 and 8 to 19
// - Present address incremented by twenty-bit counter, written back with fresh parity
// - Counter output below its input reports a counter error
// - Present equal final ends transfer; present above final is error; final parity checked
// - Eight-bit rotating state loads from write bits 8-15, reads back likewise
// - Zero inactive, 01010101 active, alternates with 10101010, request loads 00001111
// - State holds on internal error, awaited response, or single step without strobe
// - Request register decodes unit, register select and device address fields
// - Direct load and read need no request; internal bus load needs acknowledged request
// - At each word transfer start, present above final sets an error bit
`default_nettype none
module dsa_core #(
	parameter logic [5:0] UNIT_ADDR = dsa_pkg::UNIT_ADDR_DEF,
	parameter logic [5:0] PCH_ADDR = dsa_pkg::PCH_ADDR_DEF,
	parameter int NUM_DEV = dsa_pkg::NUM_DEV
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [15:0] host_request_reg_in,
	input wire logic [15:0] host_write_reg_in,
	input wire dsa_pkg::dsa_strobe_t strobe_in,
	input wire logic store_access_enable_in,
	input wire logic single_step_mode_in,
	input wire logic sync_in,
	input wire logic bus_go_in,
	input wire logic store_complete_in,
	input wire logic store_error_c_in,
	input wire logic store_error_in,
	input wire logic [15:0] store_data_in,
	input wire logic [1:0] store_data_par_in,
	output logic [15:0] host_read_out,
	output dsa_pkg::dsa_bus_t bus_out,
	output dsa_pkg::dsa_err_t error_out,
	output logic end_of_transfer_out,
	output logic abort_out,
	output logic request_ack_out,
	output logic pch_request_out
);
	logic [15:0] data_buffer [NUM_DEV];
	logic [1:0] dtb_par [NUM_DEV];
	logic [15:0] present_address_low [NUM_DEV];
	logic [15:0] final_address_low [NUM_DEV];
	logic [3:0] pa_par [NUM_DEV];
	logic [3:0] fa_par [NUM_DEV];
	logic [3:0] present_address_high [NUM_DEV];
	logic [3:0] final_address_high [NUM_DEV];
	logic [3:0] flag_nibble [NUM_DEV];
	logic [15:0] memory_data;
	logic [1:0] mdt_par;
	logic [15:0] error_word;
	logic [15:0] mask_word;
	logic [7:0] store_command;
	logic [7:0] sequencer_state;
	logic req_pending;
	logic mem_seq;
	logic adv_seq;
	logic mem_busy;
	logic pch_wait;
	dsa_pkg::dsa_err_t err;
	dsa_pkg::dsa_err_t next_err;
	logic unit_sel;
	logic pch_sel;
	logic [3:0] dev;
	dsa_pkg::dsa_sel_t rsel;
	logic [19:0] present_address;
	logic [19:0] final_address;
	logic [19:0] next_address;
	logic host_wr;
	logic seq_wr;
	logic reg_wr;
	logic step_ok;
	logic awaiting;
	logic advance;
	logic accept;
	logic in_loop;
	logic memory_trigger;
	logic store_go;
	logic data_ready;
	logic data_load;
	logic store_write_level;
	logic mdt_load;
	logic mdt_bad;
	logic s3_step;
	logic read_move;
	logic seq_end;
	logic clr;

	assign unit_sel = host_request_reg_in[dsa_pkg::RQ_UNIT_LO +: dsa_pkg::RQ_UNIT_W] == UNIT_ADDR;
	assign pch_sel = host_request_reg_in[dsa_pkg::RQ_UNIT_LO +: dsa_pkg::RQ_UNIT_W] == PCH_ADDR;
	assign dev = host_request_reg_in[dsa_pkg::RQ_DEV_LO +: dsa_pkg::DEV_W];
	assign rsel = dsa_pkg::dsa_sel_t'(host_request_reg_in[dsa_pkg::RQ_SEL_LO +: 4]);
	assign clr = strobe_in.reset && unit_sel;

	assign present_address = {present_address_high[dev], present_address_low[dev]};
	assign final_address = {final_address_high[dev], final_address_low[dev]};
	assign next_address = present_address + 20'h00001;

	// Direct load needs no request; the internal bus load happens only inside an accepted sequence
	assign host_wr = strobe_in.load && unit_sel;
	assign seq_wr = advance && sequencer_state == dsa_pkg::ST_S1 && !mem_seq;
	assign reg_wr = host_wr || seq_wr;

	// Rotation is stalled, not gated clock; a held state keeps the sequence intact
	assign step_ok = !single_step_mode_in || (strobe_in.step && unit_sel);
	assign awaiting = (mem_busy && !data_ready) || pch_wait;
	assign advance = (err == '0) && !awaiting && step_ok;
	assign in_loop = sequencer_state == dsa_pkg::ST_ACTIVE || sequencer_state == dsa_pkg::ST_ALT;
	assign accept = advance && in_loop && req_pending;
	assign seq_end = advance && sequencer_state == dsa_pkg::ST_LAST;
	assign s3_step = advance && sequencer_state == dsa_pkg::ST_S3 && mem_seq;
	assign read_move = s3_step && store_write_level && !mdt_bad;

	// Store access is refused while the host keeps this unit off the bus
	assign memory_trigger = advance && sequencer_state == dsa_pkg::ST_S1 && mem_seq
		&& store_access_enable_in;

	// Write level low means a store write
	assign store_write_level = store_command[3:0] != dsa_pkg::CMD_WRITE;
	assign mdt_load = data_load && store_write_level;
	assign mdt_bad = dsa_pkg::dsa_odd_byte(memory_data) != mdt_par;

	dsa_store_ctl u_store_ctl (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clear_in(clr),
		.trigger_in(memory_trigger),
		.bus_go_in(bus_go_in),
		.complete_in(store_complete_in),
		.error_c_in(store_error_c_in),
		.go_out(store_go),
		.seize_out(),
		.data_ready_out(data_ready),
		.data_load_out(data_load)
	);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sequencer_state <= dsa_pkg::ST_IDLE;
		end else if (clr || (strobe_in.clr_state && unit_sel)) begin
			sequencer_state <= dsa_pkg::ST_IDLE;
		end else if (host_wr && rsel == dsa_pkg::SEL_STATE) begin
			sequencer_state <= host_write_reg_in[dsa_pkg::HW_STATE_LO +: dsa_pkg::ST_W];
		end else if (accept) begin
			sequencer_state <= dsa_pkg::ST_REQ;
		end else if (seq_end) begin
			sequencer_state <= dsa_pkg::ST_ACTIVE;
		end else if (advance) begin
			sequencer_state <= {sequencer_state[6:0], sequencer_state[7]};
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			req_pending <= 1'b0;
		end else if (strobe_in.set_req && unit_sel) begin
			req_pending <= 1'b1;
		end else if (clr || (strobe_in.clr_req && unit_sel) || seq_end) begin
			req_pending <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mem_seq <= 1'b0;
			adv_seq <= 1'b0;
		end else if (accept) begin
			mem_seq <= host_request_reg_in[dsa_pkg::RQ_MEM_BIT];
			adv_seq <= host_request_reg_in[dsa_pkg::RQ_ADV_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mem_busy <= 1'b0;
		end else if (memory_trigger) begin
			mem_busy <= 1'b1;
		end else if (clr || data_ready || err.store_error) begin
			mem_busy <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pch_wait <= 1'b0;
			pch_request_out <= 1'b0;
		end else begin
			pch_request_out <= strobe_in.set_req && pch_sel;
			if (strobe_in.set_req && pch_sel) begin
				pch_wait <= 1'b1;
			end else if (clr || sync_in) begin
				pch_wait <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			request_ack_out <= 1'b0;
			end_of_transfer_out <= 1'b0;
		end else begin
			request_ack_out <= accept;
			end_of_transfer_out <= present_address == final_address;
		end
	end

	// Per-device RAMs, one word per device address
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < NUM_DEV; i++) begin
				data_buffer[i] <= 16'h0000;
				dtb_par[i] <= 2'h3;
				present_address_low[i] <= 16'h0000;
				final_address_low[i] <= 16'h0000;
				pa_par[i] <= 4'hF;
				fa_par[i] <= 4'hF;
				present_address_high[i] <= 4'h0;
				final_address_high[i] <= 4'h0;
				flag_nibble[i] <= 4'h0;
			end
		end else begin
			if (reg_wr) begin
				case (rsel)
					dsa_pkg::SEL_DTB: begin
						data_buffer[dev] <= host_write_reg_in;
						dtb_par[dev] <= dsa_pkg::dsa_odd_byte(host_write_reg_in);
					end
					dsa_pkg::SEL_PAL: begin
						present_address_low[dev] <= host_write_reg_in;
						pa_par[dev] <= dsa_pkg::dsa_odd_nib(host_write_reg_in);
					end
					dsa_pkg::SEL_FAL: begin
						final_address_low[dev] <= host_write_reg_in;
						fa_par[dev] <= dsa_pkg::dsa_odd_nib(host_write_reg_in);
					end
					dsa_pkg::SEL_PAH: present_address_high[dev] <= host_write_reg_in[3:0];
					dsa_pkg::SEL_FAH: final_address_high[dev] <= host_write_reg_in[3:0];
					dsa_pkg::SEL_FLAG: flag_nibble[dev] <= host_write_reg_in[3:0];
					default: begin
					end
				endcase
			end
			if (read_move) begin
				data_buffer[dev] <= memory_data;
				dtb_par[dev] <= mdt_par;
			end
			if (s3_step && adv_seq) begin
				present_address_low[dev] <= next_address[15:0];
				present_address_high[dev] <= next_address[19:16];
				pa_par[dev] <= dsa_pkg::dsa_odd_nib(next_address[15:0]);
			end
		end
	end

	// Shared single-copy registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			memory_data <= 16'h0000;
			mdt_par <= 2'h3;
		end else if (mdt_load) begin
			memory_data <= store_data_in;
			mdt_par <= store_data_par_in;
		end else if (advance && sequencer_state == dsa_pkg::ST_REQ && mem_seq && !store_write_level) begin
			memory_data <= data_buffer[dev];
			mdt_par <= dtb_par[dev];
		end else if (reg_wr && rsel == dsa_pkg::SEL_MDT) begin
			memory_data <= host_write_reg_in;
			mdt_par <= dsa_pkg::dsa_odd_byte(host_write_reg_in);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			error_word <= 16'h0000;
		end else if (mdt_load && dsa_pkg::dsa_odd_byte(store_data_in) != store_data_par_in) begin
			error_word <= store_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mask_word <= 16'h0000;
			store_command <= 8'h00;
		end else if (clr) begin
			mask_word <= 16'h0000;
		end else if (reg_wr && rsel == dsa_pkg::SEL_MSK) begin
			mask_word <= host_write_reg_in;
		end else if (reg_wr && rsel == dsa_pkg::SEL_STORE_COMMAND) begin
			store_command <= host_write_reg_in[7:0];
		end
	end

	// Sticky error flags; a detection in the clearing cycle still lands
	always_comb begin
		next_err = clr ? '0 : err;
		if (store_error_in && store_go) begin
			next_err.store_error = 1'b1;
		end
		if (mdt_load && dsa_pkg::dsa_odd_byte(store_data_in) != store_data_par_in) begin
			next_err.data_parity = 1'b1;
		end
		if (advance && sequencer_state == dsa_pkg::ST_REQ && mem_seq) begin
			if (dsa_pkg::dsa_odd_byte(data_buffer[dev]) != dtb_par[dev]) begin
				next_err.dtb_parity = 1'b1;
			end
			if (present_address > final_address) begin
				next_err.pa_gt_fa = 1'b1;
			end
			if (dsa_pkg::dsa_odd_nib(present_address_low[dev]) != pa_par[dev]) begin
				next_err.pa_parity = 1'b1;
			end
			if (dsa_pkg::dsa_odd_nib(final_address_low[dev]) != fa_par[dev]) begin
				next_err.fa_parity = 1'b1;
			end
		end
		if (s3_step && adv_seq && next_address < present_address) begin
			next_err.counter = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			err <= '0;
		end else begin
			err <= next_err;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			abort_out <= 1'b0;
		end else begin
			abort_out <= next_err.store_error && !err.store_error;
		end
	end

	assign error_out = err;

	// Direct read path back to the host read register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			host_read_out <= 16'h0000;
		end else begin
			case (rsel)
				dsa_pkg::SEL_DTB: host_read_out <= data_buffer[dev];
				dsa_pkg::SEL_PAL: host_read_out <= present_address_low[dev];
				dsa_pkg::SEL_FAL: host_read_out <= final_address_low[dev];
				dsa_pkg::SEL_MDT: host_read_out <= memory_data;
				dsa_pkg::SEL_EDT: host_read_out <= error_word;
				dsa_pkg::SEL_MSK: host_read_out <= mask_word;
				dsa_pkg::SEL_PAH: host_read_out <= {12'h000, present_address_high[dev]};
				dsa_pkg::SEL_FAH: host_read_out <= {12'h000, final_address_high[dev]};
				dsa_pkg::SEL_FLAG: host_read_out <= {12'h000, flag_nibble[dev]};
				dsa_pkg::SEL_STORE_COMMAND: host_read_out <= {8'h00, store_command};
				dsa_pkg::SEL_STATE: host_read_out <= {sequencer_state, 8'h00};
				default: host_read_out <= 16'h0000;
			endcase
		end
	end

	// Store bus gating: isolated repeaters carry this unit's address and command, and its data only on a store write
	always_comb begin
		bus_out = '0;
		bus_out.go = store_go;
		bus_out.repeater_en = !store_go;
		if (store_go) begin
			bus_out.address = present_address;
			bus_out.addr_par = {~^present_address[19:8], ~^present_address[7:0]};
			bus_out.command = store_command;
			bus_out.data_oe = !store_write_level;
		end
		if (bus_out.data_oe) begin
			bus_out.data = memory_data;
			bus_out.data_par = mdt_par;
		end
	end
endmodule
`default_nettype wire

// file: verification/dsa_core_properties.sv
// Port-level checks of the DMA store access core
`default_nettype none
module dsa_core_checker #(
	parameter logic [5:0] UNIT_ADDR = dsa_pkg::UNIT_ADDR_DEF,
	parameter logic [5:0] PCH_ADDR = dsa_pkg::PCH_ADDR_DEF
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [15:0] host_request_reg_in,
	input wire dsa_pkg::dsa_strobe_t strobe_in,
	input wire logic store_access_enable_in,
	input wire logic store_complete_in,
	input wire dsa_pkg::dsa_bus_t bus_out,
	input wire dsa_pkg::dsa_err_t error_out,
	input wire logic abort_out,
	input wire logic request_ack_out,
	input wire logic pch_request_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	AST_REPEATER: assert property (bus_out.repeater_en == !bus_out.go)
		else $error("repeater enable not inverse of go");
	AST_IDLE_BUS: assert property (!bus_out.go |-> bus_out.address == 20'h0 && bus_out.command == 8'h0)
		else $error("address or command on idle bus");
	AST_ADDR_PAR: assert property (bus_out.go |-> bus_out.addr_par ==
		{~^bus_out.address[19:8], ~^bus_out.address[7:0]})
		else $error("bad store address parity");
	AST_DATA_PAR: assert property (bus_out.data_oe |-> bus_out.data_par ==
		{~^bus_out.data[15:8], ~^bus_out.data[7:0]})
		else $error("bad store data parity");
	AST_NO_ACCESS: assert property (!store_access_enable_in && !bus_out.go |=> !bus_out.go)
		else $error("go raised while access disabled");
	AST_RELEASE: assert property ($rose(store_complete_in) |-> ##[1:5] !bus_out.go)
		else $error("go held after complete");
	AST_ABORT: assert property (abort_out |-> ##[0:1] error_out.store_error)
		else $error("abort without store error flag");
	AST_ACK_PULSE: assert property (request_ack_out |=> !request_ack_out)
		else $error("acknowledge longer than one cycle");
	AST_PCH_REQ: assert property (pch_request_out |->
		$past(strobe_in.set_req && host_request_reg_in[15:10] == PCH_ADDR))
		else $error("channel request without its strobe");
	AST_HOST_RESET: assert property (strobe_in.reset && host_request_reg_in[15:10] == UNIT_ADDR
		|=> !bus_out.go)
		else $error("go survived reset strobe");
endmodule
bind dsa_core dsa_core_checker #(.UNIT_ADDR(UNIT_ADDR), .PCH_ADDR(PCH_ADDR)) i_chk (.clk_in, .rst_n_in,
	.host_request_reg_in, .strobe_in, .store_access_enable_in, .store_complete_in, .bus_out, .error_out,
	.abort_out, .request_ack_out, .pch_request_out);
`default_nettype wire

// file: verification/dsa_store_model.sv
// Behavioural main store answering the core's store bus
`default_nettype none
module dsa_store_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire dsa_pkg::dsa_bus_t bus_in,
	input wire logic bad_par_in,
	input wire logic err_in,
	input wire logic [15:0] word_in,
	output logic complete_out,
	output logic error_out,
	output logic [15:0] data_out,
	output logic [1:0] par_out,
	output logic [19:0] addr_out,
	output logic [15:0] wdata_out,
	output logic [7:0] cmd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{cnt, complete_out, error_out, data_out, par_out} <= '0;
		end else if (!bus_in.go) begin
			cnt <= 4'h0;
			complete_out <= 1'b0;
			error_out <= 1'b0;
			// Released lines keep changing so stale data cannot pass
			data_out <= ~data_out;
			par_out <= ~par_out;
		end else begin
			cnt <= cnt + 4'h1;
			if (cnt == 4'h0) begin
				addr_out <= bus_in.address;
				wdata_out <= bus_in.data;
				cmd_out <= bus_in.command;
			end
			if (cnt == 4'h3) begin
				complete_out <= 1'b1;
				error_out <= err_in;
				data_out <= word_in;
				par_out <= {~^word_in[15:8], ~^word_in[7:0] ^ bad_par_in};
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the DMA store access core
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [5:0] UA = dsa_pkg::UNIT_ADDR_DEF;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [15:0] rq = 16'h0;
	logic [15:0] wr = 16'h0;
	dsa_pkg::dsa_strobe_t stb = '0;
	logic en = 1'b0;
	logic ss = 1'b0;
	logic bad = 1'b0;
	logic serr = 1'b0;
	logic obus = 1'b0;
	logic [15:0] rword = 16'h0;
	logic cmp, sto_err, eot, abrt, ack, parallel_channel;
	logic [15:0] sdata, rd, m_data;
	logic [1:0] spar;
	logic [19:0] m_addr;
	logic [7:0] m_cmd, a;
	dsa_pkg::dsa_bus_t bus;
	dsa_pkg::dsa_err_t err;
	logic [15:0] msk [12] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0, 16'hFFFF, 16'hF, 16'hF, 16'hF,
		16'hFF, 16'h0, 16'h0};
	int err_count = 0;
	int n_tests = 0;
	dsa_core i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .host_request_reg_in(rq), .host_write_reg_in(wr),
		.strobe_in(stb), .store_access_enable_in(en), .single_step_mode_in(ss), .sync_in(1'b0),
		.bus_go_in(obus), .store_complete_in(cmp), .store_error_c_in(1'b0), .store_error_in(sto_err),
		.store_data_in(sdata), .store_data_par_in(spar), .host_read_out(rd), .bus_out(bus), .error_out(err),
		.end_of_transfer_out(eot), .abort_out(abrt), .request_ack_out(ack), .pch_request_out(parallel_channel));
	dsa_store_model i_mem (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus), .bad_par_in(bad), .err_in(serr),
		.word_in(rword), .complete_out(cmp), .error_out(sto_err), .data_out(sdata), .par_out(spar),
		.addr_out(m_addr), .wdata_out(m_data), .cmd_out(m_cmd));
	task automatic tally_and_finish();
		$display("mismatches %0d of %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// Trailing idle cycle keeps two strobes from landing in one time step
	task automatic pulse(input int b, input logic [15:0] r);
		rq = r;
		stb = dsa_pkg::dsa_strobe_t'(6'h1 << b);
		cyc(1);
		stb = '0;
		cyc(1);
	endtask
	task automatic wreg(input logic [3:0] s, input logic [3:0] d, input logic [15:0] v);
		wr = v;
		pulse(1, {UA, 1'b0, s, 1'b0, d});
	endtask
	task automatic rreg(input logic [3:0] s, input logic [3:0] d, input logic [15:0] e);
		rq = {UA, 1'b0, s, 1'b0, d};
		cyc(2);
		chk16(rd, e);
	endtask
	task automatic req(input logic inc);
		rq = {UA, 1'b1, 4'h0, inc, 4'h2};
		stb.set_req = 1'b1;
		cyc(1);
		stb = '0;
		for (int i = 0; i < 99 && ack !== 1'b1; i++)
			cyc(1);
		chk16({15'h0, ack}, 16'h1);
	endtask
	task automatic wait_go(input logic v);
		for (int i = 0; i < 99 && bus.go !== v; i++)
			cyc(1);
		chk16({15'h0, bus.go}, {15'h0, v});
	endtask
	task automatic mseq(input logic inc);
		req(inc);
		wait_go(1'b1);
		wait_go(1'b0);
		cyc(12);
	endtask
	initial begin
		forever #2 clk_in = ~clk_in;
	end
	initial begin
		#100us;
		err_count++;
		tally_and_finish();
	end
	initial begin
		cyc(20);
		rst_n_in = 1'b1;
		cyc(3);
		en = 1'b1;
		for (int s = 0; s < 10; s++)
			wreg(s[3:0], 4'h1, 16'hA5C3);
		for (int s = 0; s < 12; s++)
			rreg(s[3:0], 4'h1, 16'hA5C3 & msk[s]);
		wreg(4'h0, 4'h0, 16'h1357);
		wreg(4'h0, 4'hF, 16'h2468);
		rreg(4'h0, 4'h0, 16'h1357);
		rreg(4'h0, 4'hF, 16'h2468);
		rreg(4'h3, 4'h9, 16'hA5C3);
		ss = 1'b1;
		wreg(4'hA, 4'h0, 16'h5500);
		rreg(4'hA, 4'h0, 16'h5500);
		cyc(3);
		chk16(rd, 16'h5500);
		pulse(0, rq);
		chk16(rd, 16'hAA00);
		ss = 1'b0;
		cyc(1);
		a = rd[15:8];
		cyc(1);
		chk16({8'h0, a ^ rd[15:8]}, 16'h00FF);
		wreg(4'h1, 4'h2, 16'hFFFF);
		wreg(4'h6, 4'h2, 16'h0003);
		wreg(4'h2, 4'h2, 16'h0000);
		wreg(4'h7, 4'h2, 16'h0004);
		wreg(4'h0, 4'h2, 16'h1234);
		wreg(4'h9, 4'h2, {12'h0, dsa_pkg::CMD_WRITE});
		rreg(4'h0, 4'h2, 16'h1234);
		chk16({15'h0, eot}, 16'h0);
		mseq(1'b1);
		chk16(m_addr[15:0], 16'hFFFF);
		chk16({12'h0, m_addr[19:16]}, 16'h3);
		chk16(m_data, 16'h1234);
		chk16({8'h0, m_cmd}, {12'h0, dsa_pkg::CMD_WRITE});
		rreg(4'h1, 4'h2, 16'h0000);
		rreg(4'h6, 4'h2, 16'h0004);
		chk16({15'h0, eot}, 16'h1);
		wreg(4'h9, 4'h2, {12'h0, dsa_pkg::CMD_READ});
		rword = 16'h5AC3;
		// Another unit holding go keeps the seize off the bus
		obus = 1'b1;
		req(1'b0);
		cyc(12);
		chk16({15'h0, bus.go}, 16'h0);
		obus = 1'b0;
		wait_go(1'b1);
		wait_go(1'b0);
		cyc(12);
		rreg(4'h0, 4'h2, 16'h5AC3);
		bad = 1'b1;
		rword = 16'h0F0E;
		mseq(1'b0);
		rreg(4'h4, 4'h2, 16'h0F0E);
		chk16({15'h0, err.data_parity}, 16'h1);
		bad = 1'b0;
		pulse(5, rq);
		rreg(4'hA, 4'h0, 16'h0000);
		chk16({9'h0, err}, 16'h0);
		wreg(4'h6, 4'h2, 16'h0005);
		wreg(4'hA, 4'h0, 16'h5500);
		req(1'b0);
		cyc(4);
		chk16({15'h0, err.pa_gt_fa}, 16'h1);
		pulse(5, rq);
		wreg(4'h6, 4'h2, 16'h0003);
		wreg(4'hA, 4'h0, 16'h5500);
		serr = 1'b1;
		mseq(1'b0);
		chk16({15'h0, err.store_error}, 16'h1);
		pulse(5, rq);
		serr = 1'b0;
		wreg(4'h1, 4'h2, 16'hFFFF);
		wreg(4'h6, 4'h2, 16'h000F);
		wreg(4'h2, 4'h2, 16'hFFFF);
		wreg(4'h7, 4'h2, 16'h000F);
		wreg(4'hA, 4'h0, 16'h5500);
		mseq(1'b1);
		chk16({15'h0, err.counter}, 16'h1);
		pulse(3, {UA, 1'b0, 4'hA, 1'b0, 4'h0});
		chk16(rd, 16'h0000);
		// A cleared request must not be accepted once the loop runs
		pulse(5, rq);
		pulse(2, rq);
		pulse(4, rq);
		wreg(4'hA, 4'h0, 16'h5500);
		a = rd[15:8];
		cyc(1);
		chk16({8'h0, a ^ rd[15:8]}, 16'h00FF);
		rq = {dsa_pkg::PCH_ADDR_DEF, 10'h0};
		stb.set_req = 1'b1;
		cyc(1);
		chk16({15'h0, parallel_channel}, 16'h1);
		stb = '0;
		cyc(1);
		chk16({15'h0, parallel_channel}, 16'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
